// File: common/timer_regs_pkg.sv
// Register map, field positions and reset values of the dual timer/PWM block
package timer_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int PRESC_W = 5;
  localparam int PRESC_CNT_W = 17;
  localparam logic [PRESC_W-1:0] PRESC_MAX = 5'h10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_POLARITY = 8'h01;
  localparam logic [7:0] IDX_T0_CMP_HI = 8'h07;
  localparam logic [7:0] IDX_T0_CMP_LO = 8'h08;
  localparam logic [7:0] IDX_T0_REL_HI = 8'h09;
  localparam logic [7:0] IDX_T0_REL_LO = 8'h0A;
  localparam logic [7:0] IDX_T1_CTRL_A = 8'h0C;
  localparam logic [7:0] IDX_T1_CTRL_B = 8'h0D;
  localparam logic [7:0] IDX_T0_CNT_HI = 8'h15;
  localparam logic [7:0] IDX_T0_CNT_LO = 8'h16;
  localparam logic [7:0] IDX_T0_FLAGS = 8'h17;
  localparam logic [7:0] IDX_T0_SNAP_HI = 8'h18;
  localparam logic [7:0] IDX_T0_SNAP_LO = 8'h19;
  localparam logic [7:0] IDX_T1_CNT_HI = 8'h1A;
  localparam logic [7:0] IDX_T1_CNT_LO = 8'h1B;
  localparam logic [7:0] IDX_T0_CTRL_A = 8'h20;
  localparam logic [7:0] IDX_T0_CTRL_B = 8'h21;
  localparam logic [7:0] IDX_T1_CMP_HI = 8'h22;
  localparam logic [7:0] IDX_T1_CMP_LO = 8'h23;
  localparam logic [7:0] IDX_T1_REL_HI = 8'h24;
  localparam logic [7:0] IDX_T1_REL_LO = 8'h25;
  // Field positions
  localparam int BIT_SETCLEAR_SENSE = 4;
  localparam int BIT_RUN_SENSE = 3;
  localparam int BIT_FUNCTION = 7;
  localparam int BIT_HALT_IRQ = 6;
  localparam int BIT_FALL_IRQ = 5;
  localparam int BIT_RISE_IRQ = 4;
  localparam int BIT_RUN_CTRL = 2;
  localparam int BIT_SETCLEAR = 0;
  localparam int BIT_WAVE_SHAPE = 5;
  // Writable bits of the polarity and control registers
  localparam logic [7:0] POL_MASK = 8'h1F;
  localparam logic [7:0] CTRL_A_MASK = 8'hF5;
  localparam logic [7:0] CTRL_B_MASK = 8'h3F;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_RELOAD_BYTE = 8'hFF;
endpackage

// File: hdl/readback_freeze.sv
// Freezes a 16-bit counter readback pair until both bytes have been read
module readback_freeze (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] live,
  input wire logic read_hi,
  input wire logic read_lo,
  output logic [15:0] view,
  output logic frozen
);
  typedef struct packed {
    logic [15:0] hold;
    logic frozen;
    logic got_hi;
    logic got_lo;
  } freeze_t;
  freeze_t q;
  freeze_t d;

  always_comb begin
    d = q;
    if (!q.frozen && (read_hi || read_lo)) begin
      d.hold = live;
      d.frozen = 1'b1;
      d.got_hi = read_hi;
      d.got_lo = read_lo;
    end else if (q.frozen) begin
      d.got_hi = q.got_hi | read_hi;
      d.got_lo = q.got_lo | read_lo;
      if (d.got_hi && d.got_lo) begin
        d.frozen = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // First read sees the live count, which is the value just frozen
  assign view = q.frozen ? q.hold : live;
  assign frozen = q.frozen;
endmodule

// File: hdl/pwm_channel.sv
// One 16-bit timer/PWM channel: prescaler, counter, waveform and stop snapshot
module pwm_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_req,
  input wire logic run_req,
  input wire logic pwm_mode,
  input wire logic square,
  input wire logic [timer_regs_pkg::PRESC_W-1:0] divide_exp,
  input wire logic [15:0] compare_in,
  input wire logic [15:0] reload_in,
  output logic [15:0] count,
  output logic wave,
  output logic wrap,
  output logic running,
  output logic set_state,
  output logic [15:0] snapshot,
  output logic stop_evt,
  output logic rise_evt,
  output logic fall_evt
);
  import timer_regs_pkg::*;
  typedef struct packed {
    logic [PRESC_CNT_W-1:0] div;
    logic [15:0] count;
    logic [15:0] cmp_active;
    logic wave;
    logic wrap;
    logic running;
    logic set_state;
    logic [15:0] snapshot;
    logic stop_evt;
    logic rise_evt;
    logic fall_evt;
  } chan_t;
  chan_t q;
  chan_t d;
  logic [PRESC_W-1:0] exp_eff;
  logic tick;
  logic last;

  always_comb begin
    exp_eff = (divide_exp > PRESC_MAX) ? PRESC_MAX : divide_exp;
    tick = q.div == ((17'h1 << exp_eff) - 17'h1);
    last = q.count >= (reload_in - 16'h1);
    d = q;
    d.stop_evt = 1'b0;
    d.set_state = set_req;
    // Start/stop has no say in PWM operation
    d.running = set_req & (pwm_mode | run_req);
    if (!set_req) begin
      d.div = '0;
      d.count = '0;
      d.wrap = 1'b0;
      d.cmp_active = compare_in;
    end else if (d.running) begin
      d.div = tick ? '0 : q.div + 17'h1;
      if (tick && last) begin
        d.count = '0;
        d.wrap = 1'b1;
        d.cmp_active = compare_in;
      end else if (tick) begin
        d.count = q.count + 16'h1;
      end
    end
    if (!set_req) begin
      d.wave = 1'b0;
    end else if (pwm_mode) begin
      d.wave = d.count < d.cmp_active;
    end else if (square) begin
      d.wave = d.count < (reload_in >> 1);
    end else begin
      d.wave = d.running && (d.count == 16'h0);
    end
    if (q.running && !d.running && set_req && !pwm_mode) begin
      d.snapshot = q.count;
      d.stop_evt = 1'b1;
    end
    d.rise_evt = d.wave & ~q.wave;
    d.fall_evt = ~d.wave & q.wave;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.count;
  assign wave = q.wave;
  assign wrap = q.wrap;
  assign running = q.running;
  assign set_state = q.set_state;
  assign snapshot = q.snapshot;
  assign stop_evt = q.stop_evt;
  assign rise_evt = q.rise_evt;
  assign fall_evt = q.fall_evt;
endmodule

// File: hdl/dual_pwm_timer_regs.sv
// APB register block of two 16-bit timer/PWM channels
//
// Decided for this implementation: the APB register port.
module dual_pwm_timer_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic t0_run_pin,
  input wire logic t0_setclear_pin,
  output logic t0_wave_output_pin,
  output logic t0_wave_oe_n,
  output logic t1_wave_output_pin,
  output logic t1_wave_oe_n,
  output logic t1_halt_irq,
  output logic t1_fall_irq,
  output logic t1_rise_irq
);
  import timer_regs_pkg::*;

  typedef struct packed {
    logic [7:0] polarity;
    logic [1:0][7:0] ctrl_a;
    logic [1:0][7:0] ctrl_b;
    logic [1:0][7:0] cmp_hi;
    logic [1:0][15:0] cmp;
    logic [1:0][7:0] rel_hi;
    logic [1:0][15:0] rel;
    logic [31:0] rdata;
    logic err;
    logic [1:0] run_sync;
    logic [1:0] setclear_sync;
  } regs_t;
  regs_t q;
  regs_t d;

  logic setup;
  logic wr_acc;
  logic [7:0] idx;
  logic [7:0] rbyte;
  logic hit;
  logic [1:0][15:0] count;
  logic [1:0][15:0] view;
  logic [1:0] frozen;
  logic [1:0] wave;
  logic [1:0] wrap;
  logic [1:0] running;
  logic [1:0] set_state;
  logic [1:0][15:0] snapshot;
  logic [1:0] stop_evt;
  logic [1:0] rise_evt;
  logic [1:0] fall_evt;
  logic [1:0] set_req;
  logic [1:0] run_req;
  logic pin_run_active;
  logic pin_clear_active;
  logic [1:0] rd_hi;
  logic [1:0] rd_lo;

  function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi);
    byte_of = hi ? v[15:8] : v[7:0];
  endfunction

  function automatic logic [7:0] flags_of(input logic w, input logic p,
                                          input logic s, input logic r);
    flags_of = {4'h0, w, p, s, r};
  endfunction

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign idx = {2'b00, paddr[7:2]};
  // Read side effects are taken in the setup cycle, when the data is latched
  assign rd_hi[0] = setup & ~pwrite & (idx == IDX_T0_CNT_HI);
  assign rd_lo[0] = setup & ~pwrite & (idx == IDX_T0_CNT_LO);
  assign rd_hi[1] = setup & ~pwrite & (idx == IDX_T1_CNT_HI);
  assign rd_lo[1] = setup & ~pwrite & (idx == IDX_T1_CNT_LO);

  // Pins drive only after two synchroniser stages
  assign pin_run_active = q.run_sync[1] ^ q.polarity[BIT_RUN_SENSE];
  assign pin_clear_active = ~(q.setclear_sync[1] ^ q.polarity[BIT_SETCLEAR_SENSE]);
  assign run_req[0] = q.ctrl_a[0][BIT_RUN_CTRL] | pin_run_active;
  assign set_req[0] = q.ctrl_a[0][BIT_SETCLEAR] & ~pin_clear_active;
  assign run_req[1] = q.ctrl_a[1][BIT_RUN_CTRL];
  assign set_req[1] = q.ctrl_a[1][BIT_SETCLEAR];

  always_comb begin
    hit = 1'b1;
    rbyte = 8'h00;
    case (idx)
      IDX_POLARITY: rbyte = q.polarity;
      IDX_T0_CTRL_A: rbyte = q.ctrl_a[0];
      IDX_T0_CTRL_B: rbyte = q.ctrl_b[0];
      IDX_T1_CTRL_A: rbyte = q.ctrl_a[1];
      IDX_T1_CTRL_B: rbyte = q.ctrl_b[1];
      IDX_T0_CNT_HI: rbyte = byte_of(view[0], 1'b1);
      IDX_T0_CNT_LO: rbyte = byte_of(view[0], 1'b0);
      IDX_T1_CNT_HI: rbyte = byte_of(view[1], 1'b1);
      IDX_T1_CNT_LO: rbyte = byte_of(view[1], 1'b0);
      IDX_T0_FLAGS: rbyte = flags_of(wrap[0], wave[0], set_state[0], running[0]);
      IDX_T0_SNAP_HI: rbyte = byte_of(snapshot[0], 1'b1);
      IDX_T0_SNAP_LO: rbyte = byte_of(snapshot[0], 1'b0);
      // Write-only compare and reload bytes read as zero
      IDX_T0_CMP_HI, IDX_T0_CMP_LO, IDX_T0_REL_HI, IDX_T0_REL_LO: rbyte = 8'h00;
      IDX_T1_CMP_HI, IDX_T1_CMP_LO, IDX_T1_REL_HI, IDX_T1_REL_LO: rbyte = 8'h00;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    d.run_sync = {q.run_sync[0], t0_run_pin};
    d.setclear_sync = {q.setclear_sync[0], t0_setclear_pin};
    if (setup) begin
      d.rdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rbyte};
      d.err = ~hit;
    end
    if (wr_acc) begin
      case (idx)
        IDX_POLARITY: d.polarity = pwdata[7:0] & POL_MASK;
        IDX_T0_CTRL_A: d.ctrl_a[0] = pwdata[7:0] & CTRL_A_MASK;
        IDX_T1_CTRL_A: d.ctrl_a[1] = pwdata[7:0] & CTRL_A_MASK;
        IDX_T0_CTRL_B: d.ctrl_b[0] = pwdata[7:0] & CTRL_B_MASK;
        IDX_T1_CTRL_B: d.ctrl_b[1] = pwdata[7:0] & CTRL_B_MASK;
        IDX_T0_CMP_HI: d.cmp_hi[0] = pwdata[7:0];
        IDX_T1_CMP_HI: d.cmp_hi[1] = pwdata[7:0];
        IDX_T0_CMP_LO: d.cmp[0] = {q.cmp_hi[0], pwdata[7:0]};
        IDX_T1_CMP_LO: d.cmp[1] = {q.cmp_hi[1], pwdata[7:0]};
        IDX_T0_REL_HI: d.rel_hi[0] = pwdata[7:0];
        IDX_T1_REL_HI: d.rel_hi[1] = pwdata[7:0];
        IDX_T0_REL_LO: d.rel[0] = {q.rel_hi[0], pwdata[7:0]};
        IDX_T1_REL_LO: d.rel[1] = {q.rel_hi[1], pwdata[7:0]};
        default: d.err = q.err;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.rel_hi <= {RESET_RELOAD_BYTE, RESET_RELOAD_BYTE};
      q.rel <= {4{RESET_RELOAD_BYTE}};
    end else begin
      q <= d;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_chan
    pwm_channel u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .set_req(set_req[i]),
      .run_req(run_req[i]),
      .pwm_mode(q.ctrl_a[i][BIT_FUNCTION]),
      .square(q.ctrl_b[i][BIT_WAVE_SHAPE]),
      .divide_exp(q.ctrl_b[i][PRESC_W-1:0]),
      .compare_in(q.cmp[i]),
      .reload_in(q.rel[i]),
      .count(count[i]),
      .wave(wave[i]),
      .wrap(wrap[i]),
      .running(running[i]),
      .set_state(set_state[i]),
      .snapshot(snapshot[i]),
      .stop_evt(stop_evt[i]),
      .rise_evt(rise_evt[i]),
      .fall_evt(fall_evt[i])
    );
    readback_freeze u_freeze (
      .pclk(pclk),
      .presetn(presetn),
      .live(count[i]),
      .read_hi(rd_hi[i]),
      .read_lo(rd_lo[i]),
      .view(view[i]),
      .frozen(frozen[i])
    );
  end

  // Zero wait states: data and error were latched in the setup cycle
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = q.err & psel & penable;
  // The pin floats while its timer is held in reset
  assign t0_wave_output_pin = wave[0];
  assign t0_wave_oe_n = ~set_state[0];
  assign t1_wave_output_pin = wave[1];
  assign t1_wave_oe_n = ~set_state[1];
  // Request pulses for the system interrupt controller
  assign t1_halt_irq = stop_evt[1] & q.ctrl_a[1][BIT_HALT_IRQ];
  assign t1_fall_irq = fall_evt[1] & q.ctrl_a[1][BIT_FALL_IRQ];
  assign t1_rise_irq = rise_evt[1] & q.ctrl_a[1][BIT_RISE_IRQ];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_freeze_hold;
    frozen[0] && !rd_hi[0] && !rd_lo[0] |=> $stable(view[0]);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("readback changed while frozen");

  property p_freeze_release;
    rd_hi[0] && !frozen[0] ##1 (!rd_lo[0])[*2] ##1 rd_lo[0] |=> !frozen[0];
  endproperty
  a_freeze_release: assert property (p_freeze_release) else $error("pair not released");

  property p_hi_buffered;
    wr_acc && idx == IDX_T0_CMP_HI |=> $stable(q.cmp[0]) && q.cmp_hi[0] == $past(pwdata[7:0]);
  endproperty
  a_hi_buffered: assert property (p_hi_buffered) else $error("high byte not buffered");

  property p_lo_commit;
    wr_acc && idx == IDX_T0_REL_LO |=> q.rel[0] == {$past(q.rel_hi[0]), $past(pwdata[7:0])};
  endproperty
  a_lo_commit: assert property (p_lo_commit) else $error("reload pair not committed");

  property p_ctrl_unused;
    setup && !pwrite && idx == IDX_T1_CTRL_A |=> prdata[3] == 1'b0 && prdata[1] == 1'b0;
  endproperty
  a_ctrl_unused: assert property (p_ctrl_unused) else $error("unused bits read nonzero");

  property p_run_status;
    !q.ctrl_a[1][BIT_SETCLEAR] ##1 !q.ctrl_a[1][BIT_SETCLEAR] |-> !running[1] && !set_state[1];
  endproperty
  a_run_status: assert property (p_run_status) else $error("timer ran while held");

  property p_pin_run;
    q.ctrl_a[0][BIT_SETCLEAR] && !q.ctrl_a[0][BIT_FUNCTION] && !q.ctrl_a[0][BIT_RUN_CTRL]
      && (q.run_sync[1] == q.polarity[BIT_RUN_SENSE]) [*2] |-> !running[0];
  endproperty
  a_pin_run: assert property (p_pin_run) else $error("run pin sense wrong");

  property p_flags_read;
    setup && !pwrite && idx == IDX_T0_FLAGS |=>
      prdata[7:0] == {4'h0, $past(wrap[0]), $past(wave[0]), $past(set_state[0]),
                      $past(running[0])};
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("status read mismatch");

  property p_irq_gate;
    t1_rise_irq |-> q.ctrl_a[1][BIT_RISE_IRQ] && t1_wave_output_pin
      && !$past(t1_wave_output_pin);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("rise request not gated");

  property p_halt_irq;
    t1_halt_irq |-> q.ctrl_a[1][BIT_HALT_IRQ] && !running[1] && $past(running[1]);
  endproperty
  a_halt_irq: assert property (p_halt_irq) else $error("stop request without stop");

  property p_wrap_clear;
    !set_req[0] |=> !wrap[0] && count[0] == 16'h0000;
  endproperty
  a_wrap_clear: assert property (p_wrap_clear) else $error("timer reset did not clear");

  property p_snapshot;
    stop_evt[0] |-> snapshot[0] == $past(count[0]);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("stop value not captured");

  // Compare in use is internal to the channel, so it is looked at through the hierarchy
  property p_pwm_high;
    set_state[1] && $past(q.ctrl_a[1][BIT_FUNCTION]) && count[1] == 16'h0000
      && g_chan[1].u_chan.q.cmp_active != 16'h0000 |-> wave[1];
  endproperty
  a_pwm_high: assert property (p_pwm_high) else $error("period did not start high");

  property p_unmapped;
    setup && idx == 8'h3F |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  c_freeze: cover property (rd_hi[0] ##[1:20] rd_lo[0]);
  c_wrap: cover property ($rose(wrap[1]));
  c_stop: cover property (stop_evt[0]);
  c_pwm_fall: cover property (q.ctrl_a[1][BIT_FUNCTION] && fall_evt[1]);
endmodule

// File: dv/tb_dual_pwm_timer_regs.sv
// Self-checking testbench of the dual timer/PWM register block over APB
module tb_dual_pwm_timer_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_regs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, d, c, l1;
  logic run_pin, sc_pin, w0, oe0, w1, oe1, ih, ifl, ir;
  int n_errors = 0;
  int compares = 0;
  int hi, nirq;
  logic [7:0] zero_idx [12] = '{IDX_POLARITY, IDX_T1_CTRL_A, IDX_T1_CTRL_B, IDX_T0_CNT_HI,
    IDX_T0_CNT_LO, IDX_T0_FLAGS, IDX_T0_SNAP_HI, IDX_T0_SNAP_LO, IDX_T1_CNT_HI,
    IDX_T1_CNT_LO, IDX_T0_REL_LO, IDX_T0_CMP_HI};

  dual_pwm_timer_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .t0_run_pin(run_pin), .t0_setclear_pin(sc_pin),
    .t0_wave_output_pin(w0), .t0_wave_oe_n(oe0), .t1_wave_output_pin(w1),
    .t1_wave_oe_n(oe1), .t1_halt_irq(ih), .t1_fall_irq(ifl), .t1_rise_irq(ir));

  always #4 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Setup cycle, then access phase held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      check(32'h0, 32'h1);
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] x;
    logic e;
    apb(1'b1, idx, wd, x, e);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] v);
    logic e;
    apb(1'b0, idx, 8'h00, v, e);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Counts high cycles of one wave pin and cycles with any timer 1 request
  task automatic measure(input int n, input logic t1, output int h, output int q);
    h = 0;
    q = 0;
    repeat (n) begin
      @(negedge pclk);
      if ((t1 ? w1 : w0) === 1'b1) h++;
      if ((ih | ifl | ir) === 1'b1) q++;
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole sequence needs about a thousand cycles
  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    run_pin = 1'b0;
    sc_pin = 1'b1;
    wait_clk(8);
    presetn <= 1'b1;
    foreach (zero_idx[i]) begin
      rd(zero_idx[i], d);
      check(d, 32'h0);
    end
    begin
      logic e;
      apb(1'b0, 8'h3F, 8'h00, d, e);
      check({31'h0, e}, 32'h1);
      check(d, 32'h0);
    end
    wr(IDX_T0_SNAP_HI, 8'h55);
    rd(IDX_T0_SNAP_HI, d);
    check(d, 32'h0);
    wr(IDX_POLARITY, 8'hFF);
    rd(IDX_POLARITY, d);
    check(d, {24'h0, POL_MASK});
    wr(IDX_POLARITY, 8'h00);
    // Timer 1 unused control bits must stay zero, so masking is probed on timer 0
    wr(IDX_T0_CTRL_A, 8'hFF);
    rd(IDX_T0_CTRL_A, d);
    check(d, 32'hF5);
    wr(IDX_T0_CTRL_A, 8'h00);
    // Control B mask: bits 7 and 6 read back as zero, prescaler field written as 0x10
    wr(IDX_T1_CTRL_B, 8'hF0);
    rd(IDX_T1_CTRL_B, d);
    check(d, 32'h30);
    wr(IDX_T1_CTRL_B, 8'h00);
    // Reload left at reset value: the output stays high until the count reaches compare 0x100, beyond the 200 measured cycles
    wr(IDX_T1_CMP_HI, 8'h01);
    wr(IDX_T1_CMP_LO, 8'h00);
    wr(IDX_T1_CTRL_A, 8'h81);
    // The output register follows one clock after the set bit lands
    wait_clk(2);
    measure(200, 1'b1, hi, nirq);
    check(hi, 200);
    check({31'h0, oe1}, 32'h0);
    wr(IDX_T1_REL_HI, 8'h00);
    wr(IDX_T1_REL_LO, 8'h10);
    wr(IDX_T1_CMP_HI, 8'h00);
    wr(IDX_T1_CMP_LO, 8'h04);
    wait_clk(20);
    measure(32, 1'b1, hi, nirq);
    check(hi, 8);
    check(nirq, 0);
    wr(IDX_T1_CTRL_A, 8'hA1);
    measure(32, 1'b1, hi, nirq);
    check(nirq, 2);
    wr(IDX_T1_CTRL_A, 8'h91);
    measure(32, 1'b1, hi, nirq);
    check(nirq, 2);
    wr(IDX_T1_CTRL_A, 8'h81);
    // Only the high byte written: the committed compare must not move
    wr(IDX_T1_CMP_HI, 8'h01);
    wait_clk(20);
    measure(32, 1'b1, hi, nirq);
    check(hi, 8);
    wr(IDX_T1_CMP_LO, 8'h00);
    wait_clk(20);
    measure(32, 1'b1, hi, nirq);
    check(hi, 32);
    wr(IDX_T1_CTRL_B, 8'h20);
    wr(IDX_T1_CTRL_A, 8'h05);
    wait_clk(20);
    measure(32, 1'b1, hi, nirq);
    check(hi, 16);
    wr(IDX_T1_CTRL_B, 8'h00);
    wait_clk(20);
    measure(32, 1'b1, hi, nirq);
    check(hi, 2);
    wr(IDX_T1_CTRL_B, 8'h21);
    wait_clk(40);
    measure(64, 1'b1, hi, nirq);
    check(hi, 32);
    wr(IDX_T1_CTRL_A, 8'h45);
    wr(IDX_T1_CTRL_A, 8'h41);
    measure(8, 1'b1, hi, nirq);
    check(nirq, 1);
    wr(IDX_T1_CTRL_A, 8'h00);
    wait_clk(4);
    check({31'h0, oe1}, 32'h1);
    // Timer 0 in timer mode, counting every clock
    wr(IDX_T0_REL_HI, 8'h02);
    wr(IDX_T0_REL_LO, 8'h00);
    wr(IDX_T0_CTRL_A, 8'h05);
    wait_clk(10);
    rd(IDX_T0_FLAGS, d);
    check(d & 32'h3, 32'h3);
    rd(IDX_T0_CNT_LO, l1);
    wait_clk(5);
    rd(IDX_T0_CNT_LO, d);
    check(d, l1);
    rd(IDX_T0_CNT_HI, d);
    rd(IDX_T0_CNT_LO, d);
    check({31'h0, d !== l1}, 32'h1);
    rd(IDX_T0_CNT_HI, c);
    wr(IDX_T0_CTRL_A, 8'h01);
    wait_clk(5);
    rd(IDX_T0_FLAGS, d);
    check(d & 32'h3, 32'h2);
    rd(IDX_T0_CNT_HI, c);
    rd(IDX_T0_CNT_LO, d);
    c = {16'h0, c[7:0], d[7:0]};
    rd(IDX_T0_SNAP_HI, d);
    rd(IDX_T0_SNAP_LO, l1);
    check({16'h0, d[7:0], l1[7:0]}, c);
    wr(IDX_T0_REL_HI, 8'h00);
    wr(IDX_T0_REL_LO, 8'h10);
    // Compare equal to reload keeps the PWM output high for the whole period
    wr(IDX_T0_CMP_HI, 8'h00);
    wr(IDX_T0_CMP_LO, 8'h10);
    wr(IDX_T0_CTRL_A, 8'h81);
    wait_clk(40);
    rd(IDX_T0_FLAGS, d);
    check(d & 32'hB, 32'hB);
    check(d & 32'h4, 32'h4);
    check({31'h0, w0}, 32'h1);
    wr(IDX_T0_CTRL_A, 8'h80);
    wait_clk(5);
    rd(IDX_T0_FLAGS, d);
    check(d, 32'h0);
    check({31'h0, oe0}, 32'h1);
    // Pin sense selection with timer 0 set but not started by software
    wr(IDX_T0_CTRL_A, 8'h01);
    run_pin <= 1'b1;
    wait_clk(5);
    rd(IDX_T0_FLAGS, d);
    check(d & 32'h1, 32'h1);
    wr(IDX_POLARITY, 8'h08);
    wait_clk(5);
    rd(IDX_T0_FLAGS, d);
    check(d & 32'h1, 32'h0);
    run_pin <= 1'b0;
    wait_clk(5);
    rd(IDX_T0_FLAGS, d);
    check(d & 32'h1, 32'h1);
    wr(IDX_POLARITY, 8'h00);
    sc_pin <= 1'b0;
    wait_clk(5);
    rd(IDX_T0_FLAGS, d);
    check(d & 32'h2, 32'h0);
    wr(IDX_POLARITY, 8'h10);
    wait_clk(5);
    rd(IDX_T0_FLAGS, d);
    check(d & 32'h2, 32'h2);
    close_out();
  end
endmodule
